// ---- hdl/ivm_pkg.sv ----
// constants and carrier types for the interrupt vector mapping block
package ivm_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FLAG_OFS = 8'h04;
  localparam logic [7:0] EN_OFS = 8'h08;
  localparam logic [7:0] PEND_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] SWSET_OFS = 8'h14;

  // control fields
  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_SPLIT_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [31:0] EN_RST = 32'h0000_0000;
  localparam logic [31:0] FLAG_RST = 32'h0000_0000;

  // status fields
  localparam int STAT_VEC_LSB = 0;
  localparam int STAT_REQ_BIT = 8;
  localparam int STAT_NMI_BIT = 9;

  // vector numbers, equal to their word addresses
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_NMI = 5'h01;
  localparam logic [4:0] VEC_SUPPLY = 5'h02;
  localparam logic [4:0] VEC_RTC_COUNT_IRQ = 5'h03;
  localparam logic [4:0] VEC_RTC_PERIODIC_IRQ = 5'h04;
  localparam logic [4:0] VEC_CUSTOM = 5'h05;
  localparam logic [4:0] VEC_PORT_A = 5'h06;
  localparam logic [4:0] VEC_PORT_B = 5'h07;
  localparam logic [4:0] VEC_TA_OVF = 5'h08;
  localparam logic [4:0] VEC_TA_HUNF = 5'h09;
  localparam logic [4:0] VEC_TA_CMP0 = 5'h0A;
  localparam logic [4:0] VEC_TA_CMP1 = 5'h0B;
  localparam logic [4:0] VEC_TA_CMP2 = 5'h0C;
  localparam logic [4:0] VEC_TB0 = 5'h0D;
  localparam logic [4:0] VEC_TWI_CLIENT = 5'h0E;
  localparam logic [4:0] VEC_TWI_HOST = 5'h0F;
  localparam logic [4:0] VEC_SPI = 5'h10;
  localparam logic [4:0] VEC_SER0 = 5'h11;
  localparam logic [4:0] VEC_CMP = 5'h14;
  localparam logic [4:0] VEC_CONV_ERR = 5'h15;
  localparam logic [4:0] VEC_CONV_RES = 5'h16;
  localparam logic [4:0] VEC_CONV_SMP = 5'h17;
  localparam logic [4:0] VEC_PORT_C = 5'h18;
  localparam logic [4:0] VEC_TB1 = 5'h19;
  localparam logic [4:0] VEC_SER1 = 5'h1A;
  localparam logic [4:0] VEC_NVM = 5'h1D;
  localparam logic [4:0] VEC_LAST = 5'h1D;

  // offsets inside a serial transceiver's group of three
  localparam logic [4:0] SER_RX_OFS = 5'h00;
  localparam logic [4:0] SER_DRE_OFS = 5'h01;
  localparam logic [4:0] SER_TX_OFS = 5'h02;

  // vectors that can ever carry a request (1 to 29)
  localparam logic [31:0] VEC_LIVE = 32'h3FFF_FFFE;

  // AHB encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // peripheral event pulses, one cycle each, same clock
  typedef struct packed {
    logic memory_integrity_scan;
    logic supply_level_monitor_irq;
    logic rtc_count_irq;
    logic rtc_periodic_irq;
    logic custom_logic_irq;
    logic port_a_irq;
    logic port_b_irq;
    logic port_c_irq;
    logic timer_a_overflow_irq;
    logic timer_a_low_underflow_irq;
    logic timer_a_high_underflow_irq;
    logic timer_a_compare0_irq;
    logic timer_a_compare1_irq;
    logic timer_a_compare2_irq;
    logic timer_b_first_capture_irq;
    logic timer_b_second_capture_irq;
    logic two_wire_client_irq;
    logic two_wire_host_irq;
    logic spi_irq;
    logic serial0_rx_done_irq;
    logic serial0_tx_empty_irq;
    logic serial0_tx_done_irq;
    logic serial1_rx_done_irq;
    logic serial1_tx_empty_irq;
    logic serial1_tx_done_irq;
    logic comparator_irq;
    logic converter_error_irq;
    logic converter_result_irq;
    logic converter_sample_irq;
    logic nonvolatile_ready_irq;
  } ivm_events_s;

  // request presented to the core
  typedef struct packed {
    logic irq_req;
    logic nmi_req;
    logic [4:0] vector;
  } ivm_core_s;

endpackage

// ---- hdl/ivm_vector_map.sv ----
// interrupt flags, enables and vector selection behind an AHB-Lite slave
// Notes on behaviour
// - every vector is fed by at most one peripheral; several sources may share it
// - a flag sets on its event even while its enable is clear
// - each vector has its own software-written enable bit; the sources sharing vector 8 share it
// - a source requests only while its flag and enable are both set
// - a raised request stays up until its flag is cleared
// - no maskable request reaches the core without the global enable; the non-maskable one ignores it
// - vector 0 is reset entry; vector 1 is the scan's non-maskable interrupt
// - vector 2 carries the supply level monitor
// - vector 3 carries the real-time counter overflow or compare
// - vector 4 carries the real-time counter periodic interrupt
// - vector 5 carries the custom logic interrupt
// - port pin interrupts use vectors 0x06, 0x07 and 0x18
// - vector 8 is timer A overflow, or low underflow in split mode
// - vector 9 is unused normally, timer A high underflow in split mode
// - timer A compare channels 0 to 2 use vectors 0x0A to 0x0C
// - timer B captures use vectors 0x0D and 0x19
// - two-wire client on 0x0E, host on 0x0F
// - serial peripheral interface uses vector 0x10
// - each transceiver: receive, data empty, transmit; from 0x11 and 0x1A
// - analog comparator uses vector 0x14
// - converter error, result, sample use 0x15, 0x16, 0x17
// - nonvolatile controller ready uses 0x1D, the last vector
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps

module ivm_vector_map (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // peripheral events
  input wire ivm_pkg::ivm_events_s events,
  // core request
  output ivm_pkg::ivm_core_s core
);

  logic [31:0] ev_vec;
  logic [31:0] live_mask;
  logic [31:0] flag_reg;
  logic [31:0] flag_next;
  logic [31:0] en_reg;
  logic [31:0] pend;
  logic [31:0] wclr;
  logic [31:0] wset;
  logic [1:0] ctrl_reg;
  logic gie;
  logic split;
  logic acc_en;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_next;
  logic [4:0] vec_sel;
  logic any_sel;
  ivm_pkg::ivm_core_s core_next;

  assign gie = ctrl_reg[ivm_pkg::CTRL_GIE_BIT];
  assign split = ctrl_reg[ivm_pkg::CTRL_SPLIT_BIT];

  // event routing onto vector positions
  always_comb begin
    ev_vec = 32'h0000_0000;
    ev_vec[ivm_pkg::VEC_NMI] = events.memory_integrity_scan;
    ev_vec[ivm_pkg::VEC_SUPPLY] = events.supply_level_monitor_irq;
    ev_vec[ivm_pkg::VEC_RTC_COUNT_IRQ] = events.rtc_count_irq;
    ev_vec[ivm_pkg::VEC_RTC_PERIODIC_IRQ] = events.rtc_periodic_irq;
    ev_vec[ivm_pkg::VEC_CUSTOM] = events.custom_logic_irq;
    ev_vec[ivm_pkg::VEC_PORT_A] = events.port_a_irq;
    ev_vec[ivm_pkg::VEC_PORT_B] = events.port_b_irq;
    ev_vec[ivm_pkg::VEC_PORT_C] = events.port_c_irq;
    if (split) begin
      ev_vec[ivm_pkg::VEC_TA_OVF] = events.timer_a_low_underflow_irq;
      ev_vec[ivm_pkg::VEC_TA_HUNF] = events.timer_a_high_underflow_irq;
    end else begin
      ev_vec[ivm_pkg::VEC_TA_OVF] = events.timer_a_overflow_irq;
    end
    ev_vec[ivm_pkg::VEC_TA_CMP0] = events.timer_a_compare0_irq;
    ev_vec[ivm_pkg::VEC_TA_CMP1] = events.timer_a_compare1_irq;
    ev_vec[ivm_pkg::VEC_TA_CMP2] = events.timer_a_compare2_irq;
    ev_vec[ivm_pkg::VEC_TB0] = events.timer_b_first_capture_irq;
    ev_vec[ivm_pkg::VEC_TB1] = events.timer_b_second_capture_irq;
    ev_vec[ivm_pkg::VEC_TWI_CLIENT] = events.two_wire_client_irq;
    ev_vec[ivm_pkg::VEC_TWI_HOST] = events.two_wire_host_irq;
    ev_vec[ivm_pkg::VEC_SPI] = events.spi_irq;
    ev_vec[ivm_pkg::VEC_SER0 + ivm_pkg::SER_RX_OFS] =
      events.serial0_rx_done_irq;
    ev_vec[ivm_pkg::VEC_SER0 + ivm_pkg::SER_DRE_OFS] =
      events.serial0_tx_empty_irq;
    ev_vec[ivm_pkg::VEC_SER0 + ivm_pkg::SER_TX_OFS] =
      events.serial0_tx_done_irq;
    ev_vec[ivm_pkg::VEC_SER1 + ivm_pkg::SER_RX_OFS] =
      events.serial1_rx_done_irq;
    ev_vec[ivm_pkg::VEC_SER1 + ivm_pkg::SER_DRE_OFS] =
      events.serial1_tx_empty_irq;
    ev_vec[ivm_pkg::VEC_SER1 + ivm_pkg::SER_TX_OFS] =
      events.serial1_tx_done_irq;
    ev_vec[ivm_pkg::VEC_CMP] = events.comparator_irq;
    ev_vec[ivm_pkg::VEC_CONV_ERR] = events.converter_error_irq;
    ev_vec[ivm_pkg::VEC_CONV_RES] = events.converter_result_irq;
    ev_vec[ivm_pkg::VEC_CONV_SMP] = events.converter_sample_irq;
    ev_vec[ivm_pkg::VEC_NVM] = events.nonvolatile_ready_irq;
  end

  // vector 9 carries nothing outside split mode, vector 0 never requests
  always_comb begin
    live_mask = ivm_pkg::VEC_LIVE;
    live_mask[ivm_pkg::VEC_RESET] = 1'b0;
    live_mask[ivm_pkg::VEC_TA_HUNF] = split;
  end

  // bus address phase
  assign acc_en = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = ivm_pkg::HRESP_OKAY;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= acc_en & hwrite & (hsize == ivm_pkg::HSIZE_WORD);
      wr_addr_reg <= haddr[7:0];
    end
  end

  // data phase write strobes
  always_comb begin
    wclr = 32'h0000_0000;
    wset = 32'h0000_0000;
    if (wr_pend_reg && wr_addr_reg == ivm_pkg::FLAG_OFS) begin
      wclr = hwdata;
    end
    if (wr_pend_reg && wr_addr_reg == ivm_pkg::SWSET_OFS) begin
      wset = hwdata;
    end
  end

  // control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= ivm_pkg::CTRL_RST;
    end else if (wr_pend_reg && wr_addr_reg == ivm_pkg::CTRL_OFS) begin
      ctrl_reg <= hwdata[1:0];
    end
  end

  // per-source enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_reg <= ivm_pkg::EN_RST;
    end else if (wr_pend_reg && wr_addr_reg == ivm_pkg::EN_OFS) begin
      en_reg <= hwdata & ivm_pkg::VEC_LIVE;
    end
  end

  // per-vector flags: event sets regardless of enable, set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_flag
      always_comb begin
        if (!live_mask[gi]) begin
          flag_next[gi] = 1'b0;
        end else if (ev_vec[gi] || wset[gi]) begin
          flag_next[gi] = 1'b1;
        end else if (wclr[gi]) begin
          flag_next[gi] = 1'b0;
        end else begin
          flag_next[gi] = flag_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= ivm_pkg::FLAG_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // pending sources: flag and enable both set, held while flag stays
  assign pend = flag_reg & en_reg & live_mask;

  // lowest-numbered maskable vector wins
  always_comb begin
    vec_sel = ivm_pkg::VEC_RESET;
    any_sel = 1'b0;
    for (int i = 31; i > 1; i--) begin
      if (pend[i]) begin
        vec_sel = 5'(i);
        any_sel = 1'b1;
      end
    end
  end

  // core request, non-maskable ahead of the rest
  always_comb begin
    core_next.nmi_req = pend[ivm_pkg::VEC_NMI];
    core_next.irq_req = gie & any_sel;
    if (core_next.nmi_req) begin
      core_next.vector = ivm_pkg::VEC_NMI;
    end else if (core_next.irq_req) begin
      core_next.vector = vec_sel;
    end else begin
      core_next.vector = ivm_pkg::VEC_RESET;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core <= '0;
    end else begin
      core <= core_next;
    end
  end

  // read data prepared in address phase, stands in data phase
  always_comb begin
    rd_next = 32'h0000_0000;
    case (haddr[7:0])
      ivm_pkg::CTRL_OFS: rd_next[1:0] = ctrl_reg;
      ivm_pkg::FLAG_OFS: rd_next = flag_reg;
      ivm_pkg::EN_OFS: rd_next = en_reg;
      ivm_pkg::PEND_OFS: rd_next = pend;
      ivm_pkg::STAT_OFS: begin
        rd_next[ivm_pkg::STAT_VEC_LSB +: 5] = core.vector;
        rd_next[ivm_pkg::STAT_REQ_BIT] = core.irq_req;
        rd_next[ivm_pkg::STAT_NMI_BIT] = core.nmi_req;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc_en && !hwrite) begin
      hrdata <= rd_next;
    end
  end

endmodule

// ---- bench/ivm_asserts.sv ----
// concurrent checks on the vector mapping block's ports
`timescale 1ns/100ps
module ivm_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // core request
  input wire ivm_pkg::ivm_core_s core
);
  logic rd;
  logic wr_q;
  logic wr_qq;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  // a write taken two edges back may drop the request at the next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wr_qq <= 1'b0;
    end else begin
      wr_q <= hsel && htrans[1] && hready && hwrite;
      wr_qq <= wr_q;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && hresp == ivm_pkg::HRESP_OKAY)
    else $error("bus not ready or not okay");
  a_idle_vector: assert property (
    !core.irq_req && !core.nmi_req |-> core.vector == ivm_pkg::VEC_RESET)
    else $error("vector not zero while idle");
  a_nmi_vector: assert property (
    core.nmi_req |-> core.vector == ivm_pkg::VEC_NMI)
    else $error("nmi not on vector one");
  a_vector_range: assert property (
    core.irq_req && !core.nmi_req |-> core.vector > ivm_pkg::VEC_NMI
    && core.vector <= ivm_pkg::VEC_LAST) else $error("vector out of range");
  a_req_holds: assert property (
    core.irq_req && !wr_qq |=> core.irq_req)
    else $error("request dropped without a clearing write");
  a_unmapped_zero: assert property (rd && haddr[7:0] >= 8'h18 |=> !hrdata)
    else $error("unmapped read not zero");
  a_enable_live: assert property (
    rd && haddr[7:0] == ivm_pkg::EN_OFS |=> !(hrdata & ~ivm_pkg::VEC_LIVE))
    else $error("dead enable bit reads set");
  a_pend_live: assert property (
    rd && haddr[7:0] == ivm_pkg::PEND_OFS |=> !(hrdata & ~ivm_pkg::VEC_LIVE))
    else $error("dead pending bit reads set");
  c_irq: cover property ($rose(core.irq_req));
  c_nmi: cover property ($rose(core.nmi_req));
  c_pend: cover property (rd && haddr[7:0] == ivm_pkg::PEND_OFS);
endmodule
bind ivm_vector_map ivm_asserts ivm_asserts_u (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .core(core));

// ---- bench/ivm_core_model.sv ----
// core model latching the vector it would fetch
`timescale 1ns/100ps
module ivm_core_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request from the block
  input wire ivm_pkg::ivm_core_s core,
  // vector taken
  output logic [4:0] fetched
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetched <= 5'h00;
    end else if (core.irq_req || core.nmi_req) begin
      fetched <= core.vector;
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the vector mapping block
`timescale 1ns/100ps
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = ivm_pkg::HSIZE_WORD;
  logic hreadyout;
  logic [31:0] hrdata;
  ivm_pkg::ivm_events_s events = '0;
  ivm_pkg::ivm_core_s core;
  logic [4:0] fetched;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rs = 32'h078C2FED;
  logic [31:0] r;
  logic [31:0] q;
  logic [7:0] ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h20};
  // vector of each event, most significant field first
  logic [4:0] vmap [30] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
    5'h07, 5'h18, 5'h08, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h19,
    5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h1A, 5'h1B, 5'h1C, 5'h14,
    5'h15, 5'h16, 5'h17, 5'h1D};

  always #25 hclk = ~hclk;

  ivm_vector_map dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .events(events),
    .core(core));
  ivm_core_model model_u (.hclk(hclk), .hresetn(hresetn), .core(core),
    .fetched(fetched));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // flags expected from an event word in either timer mode
  function automatic logic [31:0] flg(input logic [29:0] e, input logic s);
    logic [31:0] f;
    f = 32'h0;
    for (int k = 0; k < 30; k++) begin
      if (e[29-k] && !(s ? k == 8 : (k == 9 || k == 10))) begin
        f[vmap[k]] = 1'b1;
      end
    end
    return f;
  endfunction

  function automatic logic [4:0] low(input logic [31:0] p);
    low = 5'h00;
    for (int v = 29; v > 1; v--) begin
      if (p[v]) begin
        low = 5'(v);
      end
    end
  endfunction

  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task automatic run(input logic [29:0] e, input logic [31:0] en,
    input logic [1:0] c);
    logic [31:0] f;
    logic [31:0] p;
    logic irq;
    f = flg(e, c[1]);
    p = f & en & ivm_pkg::VEC_LIVE;
    irq = c[0] && (|p[29:2]);
    bus(1'b1, ivm_pkg::CTRL_OFS, {30'h0, c}, q);
    bus(1'b1, ivm_pkg::EN_OFS, en, q);
    @(posedge hclk);
    events <= ivm_pkg::ivm_events_s'(e);
    @(posedge hclk);
    events <= '0;
    bus(1'b0, ivm_pkg::FLAG_OFS, 32'h0, q);
    chk("flags", q, f);
    bus(1'b0, ivm_pkg::EN_OFS, 32'h0, q);
    chk("enables", q, en & ivm_pkg::VEC_LIVE);
    bus(1'b0, ivm_pkg::PEND_OFS, 32'h0, q);
    chk("pending", q, p);
    @(negedge hclk);
    chk("request", {25'h0, core}, {25'h0, irq, p[1],
      p[1] ? 5'h01 : irq ? low(p) : 5'h00});
    if (irq || p[1]) chk("fetch", fetched, p[1] ? 5'h01 : low(p));
    bus(1'b1, ivm_pkg::FLAG_OFS, 32'hFFFF_FFFF, q);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("cleared", {25'h0, core}, 32'h0);
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 32'h0, q);
      chk("reset value", q, 32'h0);
    end
    $display("reset test done");
    // software set, status, refused size, set over clear, mid-run reset
    bus(1'b1, ivm_pkg::CTRL_OFS, 32'h0000_0001, q);
    bus(1'b1, ivm_pkg::EN_OFS, 32'hFFFF_FFFF, q);
    bus(1'b1, ivm_pkg::SWSET_OFS, 32'hFFFF_FFFF, q);
    bus(1'b0, ivm_pkg::FLAG_OFS, 32'h0, q);
    chk("software set", q, ivm_pkg::VEC_LIVE & 32'hFFFF_FDFF);
    bus(1'b0, ivm_pkg::STAT_OFS, 32'h0, q);
    chk("status", q, 32'h0000_0301);
    hsize <= 3'h0;
    bus(1'b1, ivm_pkg::FLAG_OFS, 32'hFFFF_FFFF, q);
    hsize <= ivm_pkg::HSIZE_WORD;
    bus(1'b0, ivm_pkg::FLAG_OFS, 32'h0, q);
    chk("sized write", q, ivm_pkg::VEC_LIVE & 32'hFFFF_FDFF);
    fork
      bus(1'b1, ivm_pkg::FLAG_OFS, 32'hFFFF_FFFF, q);
      begin
        repeat (2) @(posedge hclk);
        events.spi_irq <= 1'b1;
        @(posedge hclk);
        events <= '0;
      end
    join
    bus(1'b0, ivm_pkg::FLAG_OFS, 32'h0, q);
    chk("set beats clear", q, 32'h1 << ivm_pkg::VEC_SPI);
    @(negedge hclk);
    chk("spi request", {25'h0, core}, 32'h0000_0050);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk("core after reset", {25'h0, core}, 32'h0);
    bus(1'b0, ivm_pkg::FLAG_OFS, 32'h0, q);
    chk("flags after reset", q, ivm_pkg::FLAG_RST);
    bus(1'b0, ivm_pkg::CTRL_OFS, 32'h0, q);
    chk("control after reset", q, 32'h0);
    $display("corner test done");
    for (int k = 0; k < 30; k++) begin
      run(30'h1 << k, ivm_pkg::VEC_LIVE, 2'h1);
      run(30'h1 << k, ivm_pkg::VEC_LIVE, 2'h3);
    end
    $display("vector table test done");
    for (int k = 0; k < 40; k++) begin
      r = xs(rs);
      rs = xs(r);
      run(r[29:0] & rs[29:0], rs, r[31:30]);
    end
    $display("random test done");
    wrap_up();
  end
endmodule
